/* File: common/port_power_pkg.sv */
package port_power_pkg;
  // Clock rate
  localparam int CLK_MHZ = 200;
  // Downstream port numbering
  localparam int FIRST_PORT = 2;
  localparam int LAST_PORT = 4;
  localparam int NUM_PORTS = LAST_PORT - FIRST_PORT + 1;
  // Upstream supply debounce, least time
  localparam int SUPPLY_DEBOUNCE_US = 100;
  localparam int SUPPLY_DEBOUNCE_CYCLES = SUPPLY_DEBOUNCE_US * CLK_MHZ;
  // Over-current glitch filter, least time
  localparam int OC_FILTER_NS = 1000;
  localparam int OC_FILTER_CYCLES = (OC_FILTER_NS * CLK_MHZ + 999) / 1000;
  // Cycles after release before the strap is taken
  localparam int STRAP_SETTLE_CYCLES = 4;
  localparam int STRAP_CNT_W = 3;
  // Reset values
  localparam logic RST_PULLUP = 1'b0;
  localparam logic RST_SUPPLY = 1'b0;
  localparam logic RST_POLARITY = 1'b1;
  localparam logic RST_OC_RAW = 1'b1;
endpackage

/* File: core/signal_filter.sv */
`timescale 1ns/1ps
module signal_filter #(
  parameter int CYCLES = 200,
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic raw,
  output logic level,
  output logic rise,
  output logic fall
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic meta;
  logic sync;
  logic [CNT_W-1:0] count;
  wire differs = sync != level;
  wire settled = differs && (count == LAST);

  // Two-stage synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      sync <= INIT;
    end else begin
      meta <= raw;
      sync <= meta;
    end
  end

  // Stable-time counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (!differs || settled) begin
      count <= '0;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= INIT;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= settled && sync;
      fall <= settled && !sync;
      if (settled) begin
        level <= sync;
      end
    end
  end
endmodule

/* File: core/port_power_vbus_control.sv */
`timescale 1ns/1ps
// Function
// - Pull-up applied only while supply present
// - One power enable per port 2-4
// - Strap one active high, zero active low
// - During reset enables inactive from live strap
// - Low-marked names asserted at low voltage
module port_power_vbus_control #(
  parameter int SUPPLY_DEBOUNCE = port_power_pkg::SUPPLY_DEBOUNCE_CYCLES,
  parameter int OC_FILTER = port_power_pkg::OC_FILTER_CYCLES,
  parameter bit OC_AUTO_OFF = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_polarity_strap,
  input wire logic upstream_supply_sense,
  input wire logic [port_power_pkg::LAST_PORT:port_power_pkg::FIRST_PORT]
    overcurrent_sense_low,
  input wire logic [port_power_pkg::LAST_PORT:port_power_pkg::FIRST_PORT]
    port_power_request,
  input wire logic [port_power_pkg::LAST_PORT:port_power_pkg::FIRST_PORT]
    overcurrent_clear,
  output logic upstream_pullup_enable,
  output logic [port_power_pkg::LAST_PORT:port_power_pkg::FIRST_PORT]
    downstream_power_enable,
  output logic [port_power_pkg::LAST_PORT:port_power_pkg::FIRST_PORT]
    overcurrent_flag,
  output logic [port_power_pkg::LAST_PORT:port_power_pkg::FIRST_PORT]
    port_powered,
  output logic supply_present,
  output logic attach_event,
  output logic detach_event,
  output logic strap_active_high,
  output logic strap_ready
);
  localparam int LO = port_power_pkg::FIRST_PORT;
  localparam int HI = port_power_pkg::LAST_PORT;
  localparam logic [port_power_pkg::STRAP_CNT_W-1:0] SETTLE =
    port_power_pkg::STRAP_CNT_W'(port_power_pkg::STRAP_SETTLE_CYCLES);

  // Level for a port given asserted state and polarity
  function automatic logic [HI:LO] drive_level(
    input logic [HI:LO] on,
    input logic active_high
  );
    drive_level = active_high ? on : ~on;
  endfunction

  // Strap synchroniser
  logic strap_meta;
  logic strap_sync;
  logic [port_power_pkg::STRAP_CNT_W-1:0] strap_count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= port_power_pkg::RST_POLARITY;
      strap_sync <= port_power_pkg::RST_POLARITY;
    end else begin
      strap_meta <= power_polarity_strap;
      strap_sync <= strap_meta;
    end
  end

  wire strap_take = !strap_ready && (strap_count == SETTLE);
  wire strap_counting = !strap_ready && !strap_take;

  // Settle counter after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_count <= '0;
    end else if (strap_counting) begin
      strap_count <= strap_count + port_power_pkg::STRAP_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_ready <= 1'b0;
    end else if (strap_take) begin
      strap_ready <= 1'b1;
    end
  end

  // Captured polarity, kept until reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_active_high <= port_power_pkg::RST_POLARITY;
    end else if (strap_take) begin
      strap_active_high <= strap_sync;
    end
  end

  // New polarity on capture cycle, no stale glitch
  wire next_active_high = strap_take ? strap_sync : strap_active_high;

  // Upstream supply filter
  logic supply_level;
  logic supply_rise;
  logic supply_fall;

  signal_filter #(
    .CYCLES(SUPPLY_DEBOUNCE),
    .INIT(port_power_pkg::RST_SUPPLY)
  ) u_supply (
    .clk(clk),
    .rst_n(rst_n),
    .raw(upstream_supply_sense),
    .level(supply_level),
    .rise(supply_rise),
    .fall(supply_fall)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upstream_pullup_enable <= port_power_pkg::RST_PULLUP;
    end else begin
      upstream_pullup_enable <= supply_level && !supply_fall;
    end
  end

  // Filtered supply level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_present <= port_power_pkg::RST_SUPPLY;
    end else begin
      supply_present <= supply_level;
    end
  end

  // Attach pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      attach_event <= 1'b0;
    end else begin
      attach_event <= supply_rise;
    end
  end

  // Detach pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detach_event <= 1'b0;
    end else begin
      detach_event <= supply_fall;
    end
  end

  // Over-current input filters
  logic [HI:LO] oc_level_low;
  logic [HI:LO] oc_hit;

  genvar p;
  generate
    for (p = LO; p <= HI; p++) begin : g_oc
      signal_filter #(
        .CYCLES(OC_FILTER),
        .INIT(port_power_pkg::RST_OC_RAW)
      ) u_oc (
        .clk(clk),
        .rst_n(rst_n),
        .raw(overcurrent_sense_low[p]),
        .level(oc_level_low[p]),
        .rise(),
        .fall(oc_hit[p])
      );
    end
  endgenerate

  // Active-low sense inverted to asserted form
  wire [HI:LO] oc_active = ~oc_level_low;
  wire [HI:LO] oc_set = oc_hit | (oc_active & port_powered);

  // Sticky flags, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overcurrent_flag <= '0;
    end else begin
      overcurrent_flag <= oc_set | (overcurrent_flag & ~overcurrent_clear);
    end
  end

  // Port is on when requested and not faulted
  wire [HI:LO] fault_block = OC_AUTO_OFF ? (overcurrent_flag | oc_set) :
    {port_power_pkg::NUM_PORTS{1'b0}};
  wire [HI:LO] next_powered = strap_ready ?
    (port_power_request & ~fault_block) : {port_power_pkg::NUM_PORTS{1'b0}};

  // Power only on request after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_powered <= '0;
    end else begin
      port_powered <= next_powered;
    end
  end

  logic [HI:LO] enable_pin;
  wire [HI:LO] next_pin = drive_level(next_powered, next_active_high);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_pin <= '0;
    end else begin
      enable_pin <= next_pin;
    end
  end

  // Inactive level from live strap in reset
  wire [HI:LO] reset_level = drive_level({port_power_pkg::NUM_PORTS{1'b0}},
    power_polarity_strap);
  wire use_register = rst_n && strap_ready;

  assign downstream_power_enable = use_register ? enable_pin : reset_level;
endmodule

/* File: tb/port_power_checks_properties.sv */
`timescale 1ns/1ps
module port_power_checks (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_polarity_strap,
  input wire logic [4:2] port_power_request,
  input wire logic upstream_pullup_enable,
  input wire logic [4:2] downstream_power_enable,
  input wire logic [4:2] overcurrent_flag,
  input wire logic [4:2] port_powered,
  input wire logic supply_present,
  input wire logic attach_event,
  input wire logic detach_event,
  input wire logic strap_active_high,
  input wire logic strap_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence attach_s;
    attach_event ##1 !attach_event;
  endsequence
  sequence detach_s;
    detach_event ##1 !detach_event;
  endsequence
  chk_pullup_supply: assert property (
    upstream_pullup_enable |-> supply_present) else $error("pullup early");
  chk_attach_pulse: assert property (
    $rose(supply_present) |-> attach_s) else $error("attach pulse");
  chk_detach_pulse: assert property (
    $fell(supply_present) |-> detach_s) else $error("detach pulse");
  chk_pin_map: assert property (
    strap_ready |-> downstream_power_enable ==
    (strap_active_high ? port_powered : ~port_powered)) else $error("pin");
  chk_strap_kept: assert property (
    strap_ready |-> strap_active_high == power_polarity_strap)
    else $error("strap capture");
  chk_reset_off: assert property (@(posedge clk) disable iff (1'b0)
    !strap_ready |-> downstream_power_enable == {3{~power_polarity_strap}})
    else $error("enable active in reset");
  chk_need_request: assert property (
    (port_powered & ~$past(port_power_request)) == 3'h0)
    else $error("power without request");
  chk_fault_off: assert property (
    (overcurrent_flag & port_powered) == 3'h0) else $error("fault on");
endmodule
bind port_power_vbus_control port_power_checks chk (
  .clk(clk),
  .rst_n(rst_n),
  .power_polarity_strap(power_polarity_strap),
  .port_power_request(port_power_request),
  .upstream_pullup_enable(upstream_pullup_enable),
  .downstream_power_enable(downstream_power_enable),
  .overcurrent_flag(overcurrent_flag),
  .port_powered(port_powered),
  .supply_present(supply_present),
  .attach_event(attach_event),
  .detach_event(detach_event),
  .strap_active_high(strap_active_high),
  .strap_ready(strap_ready)
);

/* File: tb/power_switch_model.sv */
`timescale 1ns/1ps
module power_switch_model (
  input wire logic power_polarity_strap,
  input wire logic [4:2] downstream_power_enable,
  input wire logic supply_on,
  input wire logic [4:2] fault,
  output logic upstream_supply_sense,
  output logic [4:2] overcurrent_sense_low,
  output logic [4:2] switch_on
);
  assign switch_on = power_polarity_strap ? downstream_power_enable :
    ~downstream_power_enable;
  assign overcurrent_sense_low = ~fault;
  assign upstream_supply_sense = supply_on;
endmodule

/* File: tb/port_power_vbus_control_test.sv */
`timescale 1ns/1ps
module port_power_vbus_control_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_polarity_strap = 1'b1;
  logic supply_on = 1'b0;
  logic [4:2] fault = 3'h0;
  logic [4:2] port_power_request = 3'h0;
  logic [4:2] overcurrent_clear = 3'h0;
  logic upstream_supply_sense, upstream_pullup_enable, supply_present;
  logic attach_event, detach_event, strap_active_high, strap_ready;
  logic [4:2] downstream_power_enable, overcurrent_flag, port_powered;
  logic [4:2] overcurrent_sense_low, switch_on;
  int fails = 0;
  int n_compared = 0;
  port_power_vbus_control #(.SUPPLY_DEBOUNCE(8), .OC_FILTER(4)) uut (
    .clk(clk),
    .rst_n(rst_n),
    .power_polarity_strap(power_polarity_strap),
    .upstream_supply_sense(upstream_supply_sense),
    .overcurrent_sense_low(overcurrent_sense_low),
    .port_power_request(port_power_request),
    .overcurrent_clear(overcurrent_clear),
    .upstream_pullup_enable(upstream_pullup_enable),
    .downstream_power_enable(downstream_power_enable),
    .overcurrent_flag(overcurrent_flag),
    .port_powered(port_powered),
    .supply_present(supply_present),
    .attach_event(attach_event),
    .detach_event(detach_event),
    .strap_active_high(strap_active_high),
    .strap_ready(strap_ready)
  );
  power_switch_model partner (
    .power_polarity_strap(power_polarity_strap),
    .downstream_power_enable(downstream_power_enable),
    .supply_on(supply_on),
    .fault(fault),
    .upstream_supply_sense(upstream_supply_sense),
    .overcurrent_sense_low(overcurrent_sense_low),
    .switch_on(switch_on)
  );
  initial begin
    forever #2.5 clk = ~clk;
  end
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task check(input logic [4:2] got, input logic [4:2] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: cond = strap_ready;
      1: cond = upstream_pullup_enable;
      2: cond = overcurrent_flag[4];
      default: cond = detach_event;
    endcase
  endfunction
  task automatic wait_for(input int s);
    int i;
    for (i = 0; i < 100 && cond(s) !== 1'b1; i++) @(negedge clk);
    if (i == 100) begin
      check(3'h0, 3'h7);
      wrap_up();
    end
  endtask
  task automatic strap_run(input logic s);
    int p;
    rst_n = 1'b0;
    power_polarity_strap = s;
    port_power_request = 3'h7;
    repeat (16) @(negedge clk);
    check(downstream_power_enable, {3{~s}});
    power_polarity_strap = ~s;
    #1 check(downstream_power_enable, {3{s}});
    check(switch_on, 3'h0);
    @(negedge clk);
    power_polarity_strap = s;
    rst_n = 1'b1;
    wait_for(0);
    check(switch_on, 3'h0);
    check({2'h0, strap_active_high}, {2'h0, s});
    @(negedge clk);
    check(downstream_power_enable, {3{s}});
    for (p = 0; p < 3; p++) begin
      port_power_request = 3'h1 << p;
      @(negedge clk);
      check(switch_on, port_power_request);
      check(downstream_power_enable, s ? 3'h1 << p : ~(3'h1 << p));
    end
    port_power_request = 3'h0;
    @(negedge clk);
    check(downstream_power_enable, {3{~s}});
  endtask
  task supply_run;
    supply_on = 1'b1;
    repeat (4) @(negedge clk);
    supply_on = 1'b0;
    repeat (20) @(negedge clk);
    check({2'h0, upstream_pullup_enable}, 3'h0);
    supply_on = 1'b1;
    wait_for(1);
    check({supply_present, attach_event, 1'b1}, 3'h7);
    supply_on = 1'b0;
    wait_for(3);
    check({2'h0, detach_event}, 3'h1);
    check({1'b0, supply_present, upstream_pullup_enable}, 3'h0);
    @(negedge clk);
    check({2'h0, detach_event}, 3'h0);
  endtask
  task fault_run;
    port_power_request = 3'h4;
    @(negedge clk);
    fault = 3'h4;
    wait_for(2);
    check(port_powered, 3'h0);
    check(switch_on, 3'h0);
    fault = 3'h0;
    repeat (12) @(negedge clk);
    overcurrent_clear = 3'h4;
    @(negedge clk);
    overcurrent_clear = 3'h0;
    @(negedge clk);
    check(overcurrent_flag, 3'h0);
    @(negedge clk);
    check(switch_on, 3'h4);
  endtask
  initial begin
    strap_run(1'b0);
    strap_run(1'b1);
    supply_run();
    fault_run();
    wrap_up();
  end
endmodule
